// file: src/pscs_pkg.sv
package pscs_pkg;

    // ----------------------------------------------------------------
    // Interface mode codes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PSCS_MODE_SPI = 2'b00,
        PSCS_MODE_I2C = 2'b01,
        PSCS_MODE_PIN = 2'b10,
        PSCS_MODE_RSV = 2'b11
    } pscs_mode_e;

    // ----------------------------------------------------------------
    // Loader states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PSCS_ST_RESET = 2'b00,
        PSCS_ST_LOAD  = 2'b01,
        PSCS_ST_RUN   = 2'b10
    } pscs_state_e;

    // ----------------------------------------------------------------
    // Register map (word offsets in bytes)
    // ----------------------------------------------------------------
    localparam logic [3:0] PSCS_ADDR_CTRL    = 4'h0;
    localparam logic [3:0] PSCS_ADDR_STATUS  = 4'h4;
    localparam logic [3:0] PSCS_ADDR_SUPPLY  = 4'h8;
    localparam logic [3:0] PSCS_ADDR_PRESET  = 4'hc;

    // Control register fields
    localparam int PSCS_CTRL_STAT0_LSB = 0;
    localparam int PSCS_CTRL_STAT1_LSB = 2;
    localparam int PSCS_CTRL_MANSEL    = 4;
    localparam int PSCS_CTRL_REFSEL    = 5;
    localparam logic [5:0] PSCS_CTRL_RESET = 6'h11;

    // Status pin sources selectable in host modes
    localparam logic [1:0] PSCS_SRC_LOCK = 2'h0;
    localparam logic [1:0] PSCS_SRC_LOSS = 2'h1;
    localparam logic [1:0] PSCS_SRC_SEC  = 2'h2;
    localparam logic [1:0] PSCS_SRC_ZERO = 2'h3;

    localparam logic [7:0] PSCS_SUPPLY_RESET = 8'h00;
    localparam int         PSCS_NUM_PRESETS  = 32;

    // ----------------------------------------------------------------
    // Applied configuration carrier
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] mode;
        logic [4:0] preset;
        logic       pin_mode;
        logic       manual_input_selection;
        logic       supply_level_select;
    } pscs_cfg_s;

endpackage : pscs_pkg

// file: src/pscs_top.sv
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/10ps
// How it works
// - Mode pins 10 select power-up from one of 32 stored presets.
// - In pin mode the 5-bit control code picks the preset.
// - Chosen preset sets frequencies and output types at start-up.
// - Pin mode puts the input multiplexer under manual selection.
// - Manual mode routes primary or secondary input per reference-select pin.
// - Pin mode drives status pins with lock and loss-of-reference.
// - Host modes let register settings choose status pin sources.
module pscs_top (
    // Clock and reset
    input  wire logic                CLK_I,
    input  wire logic                RST_N_I,
    // Strap pins
    input  wire logic [1:0]          MODE_I,
    input  wire logic [4:0]          PRESET_CODE_I,
    input  wire logic                REF_SELECT_I,
    input  wire logic                SUPPLY_LEVEL_SELECT_I,
    // PLL status from the analogue side
    input  wire logic                PLL_LOCK_I,
    input  wire logic                REF_LOSS_I,
    // Avalon-MM slave
    input  wire logic [3:0]          AVS_ADDRESS_I,
    input  wire logic                AVS_READ_I,
    input  wire logic                AVS_WRITE_I,
    input  wire logic [31:0]         AVS_WRITEDATA_I,
    output logic      [31:0]         AVS_READDATA_O,
    output logic                     AVS_WAITREQUEST_O,
    // Configuration outputs
    output pscs_pkg::pscs_cfg_s      CFG_O,
    output logic                     CFG_VALID_O,
    output logic                     REF_SECONDARY_O,
    output logic                     LOCK_INDICATOR_PIN_O,
    output logic                     REF_LOSS_INDICATOR_PIN_O
);
    import pscs_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    pscs_state_e state_reg,    state_next;
    pscs_cfg_s   cfg_reg,      cfg_next;
    logic [5:0]  ctrl_reg,     ctrl_next;
    logic [7:0]  supply_reg,   supply_next;
    logic        ack_reg,      ack_next;
    logic [31:0] rdata_reg,    rdata_next;
    logic        refsec_reg,   refsec_next;
    logic        stat0_reg,    stat0_next;
    logic        stat1_reg,    stat1_next;
    logic        valid_reg,    valid_next;
    logic        wait_reg,     wait_next;

    logic        req;

    // Status source mux, used for both pins
    function automatic logic pick_src(input logic [1:0] sel, input logic lock,
                                      input logic loss, input logic sec);
        unique case (sel)
            PSCS_SRC_LOCK: pick_src = lock;
            PSCS_SRC_LOSS: pick_src = loss;
            PSCS_SRC_SEC:  pick_src = sec;
            PSCS_SRC_ZERO: pick_src = 1'b0;
        endcase
    endfunction : pick_src

    assign req = AVS_READ_I | AVS_WRITE_I;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    // Mode, preset and supply straps latched only in LOAD; later changes to them are ignored
    always_comb begin
        state_next  = state_reg;
        cfg_next    = cfg_reg;
        ctrl_next   = ctrl_reg;
        supply_next = supply_reg;
        ack_next    = 1'b0;
        rdata_next  = rdata_reg;
        unique case (state_reg)
            PSCS_ST_RESET: state_next = PSCS_ST_LOAD;
            PSCS_ST_LOAD: begin
                cfg_next.mode     = MODE_I;
                cfg_next.pin_mode = (MODE_I == PSCS_MODE_PIN);
                cfg_next.preset   = (MODE_I == PSCS_MODE_PIN) ? PRESET_CODE_I
                                                              : 5'h00;
                cfg_next.manual_input_selection = 1'b1;
                cfg_next.supply_level_select    = SUPPLY_LEVEL_SELECT_I;
                state_next = PSCS_ST_RUN;
            end
            PSCS_ST_RUN: begin
                // One-cycle wait then acknowledge; waitrequest drops on ack
                if (req && !ack_reg) begin
                    ack_next = 1'b1;
                    unique case (AVS_ADDRESS_I)
                        PSCS_ADDR_CTRL:   rdata_next = {26'h0, ctrl_reg};
                        PSCS_ADDR_STATUS: rdata_next = {27'h0, refsec_reg,
                                                        REF_LOSS_I, PLL_LOCK_I,
                                                        cfg_reg.mode};
                        PSCS_ADDR_SUPPLY: rdata_next = {24'h0, supply_reg};
                        PSCS_ADDR_PRESET: rdata_next = {22'h0, cfg_reg.supply_level_select,
                                                        cfg_reg.pin_mode, 3'h0,
                                                        cfg_reg.preset};
                        default:          rdata_next = 32'h0;
                    endcase
                end
                // Write lands only at the edge where waitrequest is seen low
                if (AVS_WRITE_I && ack_reg && !cfg_reg.pin_mode) begin
                    if (AVS_ADDRESS_I == PSCS_ADDR_CTRL)
                        ctrl_next = AVS_WRITEDATA_I[5:0];
                    if (AVS_ADDRESS_I == PSCS_ADDR_SUPPLY)
                        supply_next = AVS_WRITEDATA_I[7:0];
                end
            end
            default: state_next = PSCS_ST_RESET;
        endcase
        // Registered copies, so the pins carry no decode glitches
        valid_next = (state_next == PSCS_ST_RUN);
        wait_next  = ~ack_next;
    end

    // Reference routing and status pins
    always_comb begin
        if (cfg_reg.pin_mode || ctrl_reg[PSCS_CTRL_MANSEL])
            refsec_next = REF_SELECT_I;
        else
            refsec_next = ctrl_reg[PSCS_CTRL_REFSEL] | REF_LOSS_I;
        if (cfg_reg.pin_mode) begin
            stat0_next = PLL_LOCK_I;
            stat1_next = REF_LOSS_I;
        end else begin
            stat0_next = pick_src(ctrl_reg[PSCS_CTRL_STAT0_LSB +: 2],
                                  PLL_LOCK_I, REF_LOSS_I, refsec_reg);
            stat1_next = pick_src(ctrl_reg[PSCS_CTRL_STAT1_LSB +: 2],
                                  PLL_LOCK_I, REF_LOSS_I, refsec_reg);
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            state_reg  <= PSCS_ST_RESET;
            cfg_reg    <= '0;
            ctrl_reg   <= PSCS_CTRL_RESET;
            supply_reg <= PSCS_SUPPLY_RESET;
            ack_reg    <= 1'b0;
            rdata_reg  <= 32'h0;
            refsec_reg <= 1'b0;
            stat0_reg  <= 1'b0;
            stat1_reg  <= 1'b0;
            valid_reg  <= 1'b0;
            wait_reg   <= 1'b1;
        end else begin
            state_reg  <= state_next;
            cfg_reg    <= cfg_next;
            ctrl_reg   <= ctrl_next;
            supply_reg <= supply_next;
            ack_reg    <= ack_next;
            rdata_reg  <= rdata_next;
            refsec_reg <= refsec_next;
            stat0_reg  <= stat0_next;
            stat1_reg  <= stat1_next;
            valid_reg  <= valid_next;
            wait_reg   <= wait_next;
        end
    end

    // Outputs straight from flops
    assign CFG_O                    = cfg_reg;
    assign CFG_VALID_O              = valid_reg;
    assign AVS_WAITREQUEST_O        = wait_reg;
    assign AVS_READDATA_O           = rdata_reg;
    assign REF_SECONDARY_O          = refsec_reg;
    assign LOCK_INDICATOR_PIN_O     = stat0_reg;
    assign REF_LOSS_INDICATOR_PIN_O = stat1_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    cfg_held_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (state_reg == PSCS_ST_RUN) |=> $stable(cfg_reg))
        else $error("configuration changed after load");
    pin_decode_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (state_reg == PSCS_ST_LOAD) |=> (cfg_reg.pin_mode == ($past(MODE_I) == 2'b10)))
        else $error("pin mode decode wrong");
    preset_pick_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (state_reg == PSCS_ST_LOAD && MODE_I == 2'b10) |=>
        (cfg_reg.preset == $past(PRESET_CODE_I)))
        else $error("preset not captured");
    preset_valid_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (state_reg == PSCS_ST_LOAD) |=> CFG_VALID_O)
        else $error("configuration not applied");
    manual_mux_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        CFG_VALID_O |-> cfg_reg.manual_input_selection)
        else $error("mux not manual");
    ref_route_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (cfg_reg.pin_mode && CFG_VALID_O) |=> (REF_SECONDARY_O == $past(REF_SELECT_I)))
        else $error("reference select not followed");
    stat_pin_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (cfg_reg.pin_mode && $past(cfg_reg.pin_mode)) |->
        (LOCK_INDICATOR_PIN_O == $past(PLL_LOCK_I)) &&
        (REF_LOSS_INDICATOR_PIN_O == $past(REF_LOSS_I)))
        else $error("status pins wrong in pin mode");
    stat_prog_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (!cfg_reg.pin_mode && ctrl_reg[1:0] == 2'h3 && $stable(ctrl_reg)) |=>
        !LOCK_INDICATOR_PIN_O)
        else $error("status source not honoured");
    bus_ack_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (CFG_VALID_O && req && AVS_WAITREQUEST_O) |=> !AVS_WAITREQUEST_O)
        else $error("bus answer late");
    supply_land_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (AVS_WRITE_I && !AVS_WAITREQUEST_O && !cfg_reg.pin_mode &&
         AVS_ADDRESS_I == PSCS_ADDR_SUPPLY) |=>
        ({24'h0, supply_reg} == ($past(AVS_WRITEDATA_I) & 32'h000000ff)))
        else $error("supply write not landed");
    pin_ctrl_ro_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (cfg_reg.pin_mode && CFG_VALID_O) |=> $stable(ctrl_reg))
        else $error("control changed in pin mode");

endmodule : pscs_top

// file: verif/pscs_strap_model.sv
`timescale 1ns/10ps
// Board straps and analogue status seen by the loader
module pscs_strap_model (
    // Bench requests
    input  wire logic [1:0] mode_i,
    input  wire logic [4:0] code_i,
    input  wire logic       ref_i,
    input  wire logic       xtal_only_i,
    input  wire logic       supply_i,
    input  wire logic       lock_i,
    input  wire logic       loss_i,
    // Pins into the block
    output logic      [1:0] mode_o,
    output logic      [4:0] code_o,
    output logic            ref_sel_o,
    output logic            supply_o,
    output logic            lock_o,
    output logic            loss_o
);
    // ----------------------------------------------------------------
    // Strap levels
    // ----------------------------------------------------------------
    // Straps are hard levels, so no release behaviour is modelled
    assign mode_o    = mode_i;
    assign code_o    = code_i;
    assign ref_sel_o = ref_i | xtal_only_i;
    assign supply_o  = supply_i;
    // PLL status from the analogue side
    assign lock_o    = lock_i;
    assign loss_o    = loss_i;
endmodule : pscs_strap_model

// file: verif/pscs_top_tb.sv
`timescale 1ns/10ps
module pscs_top_tb;
    import pscs_pkg::*;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic        clk, rst_n, rd, wr, ref_s, xtal, sup, lock, loss;
    logic        m_ref, m_sup, m_lock, m_loss, wait_o, valid, sec, pin0, pin1;
    logic [1:0]  mode, m_mode;
    logic [4:0]  code, m_code;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata, rv;
    pscs_cfg_s   cfg;
    int          bad_count, checked;

    always #12.5 clk = ~clk;

    pscs_strap_model strap_u (.mode_i(mode), .code_i(code), .ref_i(ref_s),
        .xtal_only_i(xtal), .supply_i(sup), .lock_i(lock), .loss_i(loss),
        .mode_o(m_mode), .code_o(m_code), .ref_sel_o(m_ref), .supply_o(m_sup),
        .lock_o(m_lock), .loss_o(m_loss));

    pscs_top dut_u (.CLK_I(clk), .RST_N_I(rst_n), .MODE_I(m_mode),
        .PRESET_CODE_I(m_code), .REF_SELECT_I(m_ref), .SUPPLY_LEVEL_SELECT_I(m_sup),
        .PLL_LOCK_I(m_lock), .REF_LOSS_I(m_loss), .AVS_ADDRESS_I(addr),
        .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
        .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wait_o), .CFG_O(cfg),
        .CFG_VALID_O(valid), .REF_SECONDARY_O(sec),
        .LOCK_INDICATOR_PIN_O(pin0), .REF_LOSS_INDICATOR_PIN_O(pin1));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Request held until waitrequest is sampled low; watchdog cuts a hang
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        rd <= !w; wr <= w; addr <= a; wdata <= d;
        do @(posedge clk); while (wait_o !== 1'b0);
        rv = rdata;
        rd <= 1'b0; wr <= 1'b0;
    endtask : bus

    // Straps settle during reset, captured at release
    task automatic boot(input logic [1:0] m, input logic [4:0] c);
        @(posedge clk);
        rst_n <= 1'b0; mode <= m; code <= c;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : boot

    task automatic tally_and_finish;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    // Preset code 5'h1a, then straps move after capture
    task automatic t_pin;
        boot(2'b10, 5'h1a);
        chk(valid, 1'b1);
        chk(cfg, {2'b10, 5'h1a, 3'b111});
        mode <= 2'b00; code <= 5'h03; sup <= 1'b0;
        repeat (3) @(posedge clk);
        chk(cfg, {2'b10, 5'h1a, 3'b111});
        mode <= 2'b10; sup <= 1'b1;
    endtask : t_pin

    task automatic t_ref;
        ref_s <= 1'b0;
        repeat (3) @(posedge clk);
        chk(sec, 1'b0);
        ref_s <= 1'b1;
        repeat (3) @(posedge clk);
        chk(sec, 1'b1);
        // Crystal-only board ties select high
        xtal <= 1'b1; ref_s <= 1'b0;
        repeat (3) @(posedge clk);
        chk(sec, 1'b1);
        xtal <= 1'b0; ref_s <= 1'b1;
    endtask : t_ref

    // Status pins fixed in pin mode, a host write must not move them
    task automatic t_stat;
        bus(1'b1, PSCS_ADDR_CTRL, 32'h0000000f);
        bus(1'b0, PSCS_ADDR_CTRL, 32'h0);
        chk(rv, 32'h00000011);
        bus(1'b0, PSCS_ADDR_PRESET, 32'h0);
        chk(rv, 32'h0000031a);
        for (int v = 0; v < 4; v++) begin
            {lock, loss} <= v[1:0];
            repeat (2) @(posedge clk);
            chk({pin0, pin1}, v[1:0]);
        end
    endtask : t_stat

    task automatic t_host;
        logic [1:0] m;
        for (int i = 2; i >= 0; i--) begin
            m = (i == 2) ? 2'b11 : i[1:0];
            boot(m, 5'h1f);
            chk({cfg.mode, cfg.preset, cfg.pin_mode}, {m, 6'h00});
            bus(1'b0, PSCS_ADDR_STATUS, 32'h0);
            chk(rv, {27'h0, 3'b111, m});
        end
        bus(1'b0, PSCS_ADDR_PRESET, 32'h0);
        chk(rv, 32'h00000200);
        bus(1'b0, PSCS_ADDR_CTRL, 32'h0);
        chk(rv, 32'h00000011);
        lock <= 1'b1; loss <= 1'b0; ref_s <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, PSCS_ADDR_CTRL, {26'h0, 2'b01, 2'b00, s[1:0]});
            repeat (2) @(posedge clk);
            chk(pin0, (s == 0) || (s == 2));
            chk(pin1, 1'b1);
        end
        // Automatic mux: secondary only on loss of reference
        bus(1'b1, PSCS_ADDR_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        chk(sec, 1'b0);
        loss <= 1'b1;
        repeat (2) @(posedge clk);
        chk(sec, 1'b1);
        bus(1'b0, PSCS_ADDR_SUPPLY, 32'h0);
        chk(rv, 32'h0);
        bus(1'b1, PSCS_ADDR_SUPPLY, 32'h000000a5);
        bus(1'b0, PSCS_ADDR_SUPPLY, 32'h0);
        chk(rv, 32'h000000a5);
        bus(1'b0, 4'h1, 32'h0);
        chk(rv, 32'h0);
    endtask : t_host

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0; rst_n = 1'b0; rd = 1'b0; wr = 1'b0; addr = 4'h0;
        wdata = 32'h0; mode = 2'b10; code = 5'h1a; ref_s = 1'b0;
        xtal = 1'b0; sup = 1'b1; lock = 1'b0; loss = 1'b0;
        bad_count = 0; checked = 0;
        t_pin;
        t_ref;
        t_stat;
        t_host;
        tally_and_finish;
    end

    // Whole run needs under two hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        tally_and_finish;
    end
endmodule : pscs_top_tb
